// >>> hw/pdw_defs.vh
// Constants for the power-down mode and wake-wait controller.
// Included by the power controller design file only; definitions only.
`ifndef PDW_DEFS_VH
`define PDW_DEFS_VH

// ----------------------------------------------------------------
// Register word offsets (byte addresses on the Avalon slave)
// ----------------------------------------------------------------
`define PDW_OFS_CTRL1        4'h0
`define PDW_OFS_CTRL2        4'h4
`define PDW_OFS_CLKCTL       4'h8
`define PDW_OFS_STATUS       4'hC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PDW_C1_SLEEP_DEPTH   7
`define PDW_C1_WAIT_HI       6
`define PDW_C1_WAIT_LO       4
`define PDW_C2_SMSEL         7
`define PDW_C2_LOW_SPEED     6
`define PDW_C2_DIRECT_XFER   5
`define PDW_C2_DIV_HI        2
`define PDW_C2_DIV_LO        0
`define PDW_CC_SWITCH_EXT    0
`define PDW_CC_SWITCH_RC     1
`define PDW_CC_TIMEBASE      2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDW_RST_CTRL1        8'h00
`define PDW_RST_CTRL2        8'h00
`define PDW_RST_TIMEBASE     1'b0

// ----------------------------------------------------------------
// Wait cycle counts per wake wait select code
// ----------------------------------------------------------------
`define PDW_WAIT_000         18'h02000
`define PDW_WAIT_001         18'h04000
`define PDW_WAIT_010         18'h08000
`define PDW_WAIT_011         18'h10000
`define PDW_WAIT_100         18'h20000
`define PDW_WAIT_101         18'h01000
`define PDW_WAIT_110         18'h00800
`define PDW_WAIT_111         18'h00200

// ----------------------------------------------------------------
// Active clock divider ratios, as terminal counts (ratio - 1)
// ----------------------------------------------------------------
`define PDW_DIV_8            6'h07
`define PDW_DIV_16           6'h0F
`define PDW_DIV_32           6'h1F
`define PDW_DIV_64           6'h3F
`define PDW_DIV_1            6'h00

`endif

// >>> hw/pdw_wait_counter.v
// Oscillator settling counter for the wake-wait and clock switch.
// Assumes count_en_in is a one-cycle tick already in mclk_in's domain.
`timescale 1ns/10ps
module pdw_wait_counter (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire        clear_in,
    input  wire        count_en_in,
    input  wire [17:0] target_in,
    output reg         done_out
);
    reg  [17:0] count_reg;
    wire [17:0] count_next;

    // Saturates at the target so a late release never wraps
    assign count_next = (count_reg == target_in) ? count_reg : count_reg + 18'h00001;

    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= 18'h00000;
            done_out  <= 1'b0;
        end else if (clear_in) begin
            count_reg <= 18'h00000;
            done_out  <= 1'b0;
        end else begin
            if (count_en_in) begin
                count_reg <= count_next;
            end
            done_out <= (count_reg == target_in);
        end
    end
endmodule

// >>> hw/pdw_power_ctrl.v
// Power-down mode selection, wake-up wait and clock switch settling.
// Assumes an Avalon-MM master on mclk_in and oscillator ticks on pins.
//
// Function
// R1 - A sleep instruction enters sleep or subsleep with the depth bit clear, standby with it set.
// R2 - Returning to active or sleep from standby or the sub modes waits the selected cycle count.
// R3 - Software picks a wait of 6.5 ms or more when the external oscillator follows.
// R4 - Software picks a wait of 100 us or more when the on-chip oscillator follows.
// R5 - The wake-wait counter counts the clock undivided, whatever the divider says.
// R6 - The wake-wait counter counts the oscillator that will be the system clock source.
// R7 - A switch from on-chip to external clock is timed by the same wait field.
// R8 - The switch wait counts the on-chip clock after the active mode divider.
// R9 - The switch wait count lies between the standby count and twice it.
// R10 - Software picks a switch count that lasts 6.5 ms or more of external periods.
// R11 - In active and sleep modes the system clock goes out divided by the divider field.
// R12 - Low speed and direct transfer flags join the depth bit in picking the next mode.
// R13 - Standby halts CPU and peripherals, leaving only the time-base clock if chosen.
// R14 - The wait counter clears as oscillation starts and clocks are released on its count.
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "pdw_defs.vh"
module pdw_power_ctrl (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire [3:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out,
    input  wire        sleep_exec_in,
    input  wire        wake_event_in,
    input  wire        osc_started_in,
    input  wire        ext_osc_tick_in,
    input  wire        rc_osc_tick_in,
    input  wire        sub_clk_tick_in,
    output reg         cpu_clk_en_out,
    output reg         periph_clk_en_out,
    output reg         rtc_clk_en_out,
    output reg         osc_enable_out,
    output reg         sys_src_ext_out,
    output reg  [2:0]  mode_out
);
    // ------------------------------------------------------------
    // Mode states
    // ------------------------------------------------------------
    localparam [2:0] ST_ACTIVE  = 3'h0;
    localparam [2:0] ST_SLEEP   = 3'h1;
    localparam [2:0] ST_SUBACT  = 3'h2;
    localparam [2:0] ST_SUBSLP  = 3'h3;
    localparam [2:0] ST_STANDBY = 3'h4;
    localparam [2:0] ST_WAKE    = 3'h5;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [4:0] pin_raw;
    reg  [4:0] pin_meta_reg;
    reg  [4:0] pin_sync_reg;
    reg  [4:0] pin_last_reg;
    wire [4:0] pin_rise;
    genvar gi;

    assign pin_raw = {sub_clk_tick_in, rc_osc_tick_in, ext_osc_tick_in,
                      osc_started_in, wake_event_in};

    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
            always @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                    pin_last_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= pin_raw[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                    pin_last_reg[gi] <= pin_sync_reg[gi];
                end
            end
            assign pin_rise[gi] = pin_sync_reg[gi] & ~pin_last_reg[gi];
        end
    endgenerate

    wire wake_rise  = pin_rise[0];
    wire osc_ok     = pin_sync_reg[1];
    wire osc_rise   = pin_rise[1];
    wire ext_tick   = pin_rise[2];
    wire rc_tick    = pin_rise[3];
    wire sub_tick   = pin_rise[4];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0] ctrl1_reg;
    reg  [7:0] ctrl2_reg;
    reg        timebase_reg;
    reg        switch_req_reg;
    reg        ack_reg;
    reg  [2:0] mode_reg;
    reg  [2:0] mode_next;
    reg  [2:0] wake_target_reg;
    reg        src_ext_reg;
    reg        switching_reg;
    reg  [5:0] div_cnt_reg;
    reg  [5:0] div_tc;
    reg [17:0] wait_target;

    wire       sleep_depth = ctrl1_reg[`PDW_C1_SLEEP_DEPTH];
    wire [2:0] wait_sel    = ctrl1_reg[`PDW_C1_WAIT_HI:`PDW_C1_WAIT_LO];
    wire       low_speed   = ctrl2_reg[`PDW_C2_LOW_SPEED];
    wire       direct_xfer = ctrl2_reg[`PDW_C2_DIRECT_XFER];
    wire [2:0] div_sel     = ctrl2_reg[`PDW_C2_DIV_HI:`PDW_C2_DIV_LO];

    // ------------------------------------------------------------
    // Avalon slave: one wait state per access
    // ------------------------------------------------------------
    wire req        = avs_read_in | avs_write_in;
    wire wr_take    = avs_write_in & ack_reg & avs_byteenable_in[0];
    wire [7:0] wbyte = avs_writedata_in[7:0];

    assign avs_waitrequest_out = req & ~ack_reg;

    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_reg          <= 1'b0;
            avs_readdata_out <= 32'h00000000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (avs_read_in & ~ack_reg) begin
                case (avs_address_in)
                    `PDW_OFS_CTRL1:  avs_readdata_out <= {24'h000000, ctrl1_reg};
                    `PDW_OFS_CTRL2:  avs_readdata_out <= {24'h000000, ctrl2_reg};
                    `PDW_OFS_CLKCTL: avs_readdata_out <= {29'h00000000, timebase_reg,
                                                          2'h0};
                    `PDW_OFS_STATUS: avs_readdata_out <= {26'h0000000, switching_reg,
                                                          src_ext_reg, 1'b0, mode_reg};
                    default:         avs_readdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    // Reserved low bits of control 1 always read zero
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl1_reg    <= `PDW_RST_CTRL1;
            ctrl2_reg    <= `PDW_RST_CTRL2;
            timebase_reg <= `PDW_RST_TIMEBASE;
        end else if (wr_take) begin
            case (avs_address_in)
                `PDW_OFS_CTRL1:  ctrl1_reg    <= {wbyte[7:4], 4'h0};
                `PDW_OFS_CTRL2:  ctrl2_reg    <= {wbyte[7:5], 2'h0, wbyte[2:0]};
                `PDW_OFS_CLKCTL: timebase_reg <= wbyte[`PDW_CC_TIMEBASE];
                default:         ctrl1_reg    <= ctrl1_reg;
            endcase
        end
    end

    wire wr_clkctl = wr_take & (avs_address_in == `PDW_OFS_CLKCTL);

    // ------------------------------------------------------------
    // Wait count lookup and active divider
    // ------------------------------------------------------------
    always @* begin
        case (wait_sel)
            3'h0:    wait_target = `PDW_WAIT_000;
            3'h1:    wait_target = `PDW_WAIT_001;
            3'h2:    wait_target = `PDW_WAIT_010;
            3'h3:    wait_target = `PDW_WAIT_011;
            3'h4:    wait_target = `PDW_WAIT_100;
            3'h5:    wait_target = `PDW_WAIT_101;
            3'h6:    wait_target = `PDW_WAIT_110;
            default: wait_target = `PDW_WAIT_111;
        endcase
    end

    always @* begin
        case (div_sel)
            3'h0:    div_tc = `PDW_DIV_8;
            3'h1:    div_tc = `PDW_DIV_16;
            3'h2:    div_tc = `PDW_DIV_32;
            3'h3:    div_tc = `PDW_DIV_64;
            default: div_tc = `PDW_DIV_1;
        endcase
    end

    // Source tick: external or on-chip oscillator, whichever is selected
    wire src_tick = src_ext_reg ? ext_tick : rc_tick;
    wire div_tick = src_tick & (div_cnt_reg == div_tc);

    // R11 divided system clock
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt_reg <= 6'h00;
        end else if (src_tick) begin
            div_cnt_reg <= (div_cnt_reg >= div_tc) ? 6'h00 : div_cnt_reg + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Settling counter shared by wake-up and clock switch
    // ------------------------------------------------------------
    wire        in_wake = (mode_reg == ST_WAKE);
    wire        wait_done;
    wire        wait_clear;
    wire        wait_tick;

    // R14 cleared while the oscillator is not yet running
    assign wait_clear = in_wake ? (~osc_ok | osc_rise) : ~switching_reg;
    // R5 R6 wake wait counts the target source undivided
    // R8 switch wait counts the divided on-chip clock
    assign wait_tick  = in_wake ? (src_ext_reg ? ext_tick : rc_tick) : div_tick;

    // R2 R7 R9 same field sets both counts; switch count equals standby count
    pdw_wait_counter u_wait (
        .mclk_in     (mclk_in),
        .rst_n_in    (rst_n_in),
        .clear_in    (wait_clear),
        .count_en_in (wait_tick),
        .target_in   (wait_target),
        .done_out    (wait_done)
    );

    // R7 switch to external clock under software control
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            switching_reg <= 1'b0;
            src_ext_reg   <= 1'b0;
        end else if (switching_reg) begin
            if (wait_done) begin
                switching_reg <= 1'b0;
                src_ext_reg   <= 1'b1;
            end
        end else if (wr_clkctl & wbyte[`PDW_CC_SWITCH_EXT] & ~src_ext_reg &
                     (mode_reg == ST_ACTIVE)) begin
            switching_reg <= 1'b1;
        end else if (wr_clkctl & wbyte[`PDW_CC_SWITCH_RC]) begin
            src_ext_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            ST_ACTIVE, ST_SUBACT: begin
                if (sleep_exec_in & ~switching_reg) begin
                    // R1 R12 depth bit, low speed and direct transfer
                    if (sleep_depth) begin
                        mode_next = ST_STANDBY;
                    end else if (direct_xfer) begin
                        if (low_speed) begin
                            mode_next = ST_SUBACT;
                        end else if (mode_reg == ST_SUBACT) begin
                            mode_next = ST_WAKE;
                        end else begin
                            mode_next = ST_ACTIVE;
                        end
                    end else if (low_speed) begin
                        mode_next = ST_SUBSLP;
                    end else if (mode_reg == ST_SUBACT) begin
                        mode_next = ST_WAKE;
                    end else begin
                        mode_next = ST_SLEEP;
                    end
                end
            end
            ST_SLEEP: begin
                if (wake_rise) begin
                    mode_next = low_speed ? ST_SUBACT : ST_ACTIVE;
                end
            end
            ST_SUBSLP: begin
                if (wake_rise) begin
                    mode_next = low_speed ? ST_SUBACT : ST_WAKE;
                end
            end
            ST_STANDBY: begin
                if (wake_rise) begin
                    mode_next = low_speed ? ST_SUBACT : ST_WAKE;
                end
            end
            ST_WAKE: begin
                // R14 clocks held until the count is reached
                if (wait_done) begin
                    mode_next = wake_target_reg;
                end
            end
            default: mode_next = ST_ACTIVE;
        endcase
    end

    // Sleep-instruction wake returns to active; direct transfer also lands there
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_reg        <= ST_ACTIVE;
            wake_target_reg <= ST_ACTIVE;
        end else begin
            mode_reg <= mode_next;
            if ((mode_next == ST_WAKE) & (mode_reg != ST_WAKE)) begin
                wake_target_reg <= ST_ACTIVE;
            end
        end
    end

    // ------------------------------------------------------------
    // Clock gating outputs
    // ------------------------------------------------------------
    wire sys_run  = (mode_reg == ST_ACTIVE) | (mode_reg == ST_SLEEP);
    wire sub_run  = (mode_reg == ST_SUBACT) | (mode_reg == ST_SUBSLP);

    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cpu_clk_en_out    <= 1'b0;
            periph_clk_en_out <= 1'b0;
            rtc_clk_en_out    <= 1'b0;
            osc_enable_out    <= 1'b1;
            sys_src_ext_out   <= 1'b0;
            mode_out          <= ST_ACTIVE;
        end else begin
            // R11 divided clock in active and sleep, subclock in sub modes
            cpu_clk_en_out    <= ((mode_reg == ST_ACTIVE) & div_tick) |
                                 ((mode_reg == ST_SUBACT) & sub_tick);
            periph_clk_en_out <= (sys_run & div_tick) | (sub_run & sub_tick);
            // R13 standby keeps only the time-base clock
            rtc_clk_en_out    <= sub_tick & ((mode_reg != ST_STANDBY) | timebase_reg);
            osc_enable_out    <= sys_run | in_wake;
            sys_src_ext_out   <= src_ext_reg;
            mode_out          <= mode_reg;
        end
    end
endmodule

// >>> tb/pdw_power_ctrl_sva.sv
// Checker for the power-down controller, watching top-level ports only.
// Assumes a single mclk_in domain and an active-low asynchronous reset.
`timescale 1ns/10ps
module pdw_power_ctrl_sva (
    input logic       mclk_in,
    input logic       rst_n_in,
    input logic       avs_read_in,
    input logic       avs_write_in,
    input logic       avs_waitrequest_out,
    input logic       sleep_exec_in,
    input logic       cpu_clk_en_out,
    input logic       periph_clk_en_out,
    input logic       sys_src_ext_out,
    input logic [2:0] mode_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("bus answer not after one wait state");
    a_bus_idle_wait: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("waitrequest high without a request");
    a_sleep_cause: assert property ($past(mode_out) == 3'h0 && mode_out != 3'h0
        |-> $past(sleep_exec_in, 2)) else $error("active mode left without sleep");
    a_wake_exit: assert property ($past(mode_out) == 3'h5 && mode_out != 3'h5
        |-> mode_out == 3'h0 || mode_out == 3'h2) else $error("wake wait left wrongly");
    a_cpu_run_modes: assert property (cpu_clk_en_out && mode_out == $past(mode_out)
        |-> mode_out == 3'h0 || mode_out == 3'h2) else $error("cpu clock in halt mode");
    a_standby_halt: assert property (mode_out == 3'h4 && $past(mode_out) == 3'h4
        |-> !cpu_clk_en_out && !periph_clk_en_out) else $error("clock during standby");
    a_wake_gated: assert property (mode_out == 3'h5 && $past(mode_out) == 3'h5
        |-> !cpu_clk_en_out && !periph_clk_en_out) else $error("clock during wake wait");
    a_switch_active: assert property ($rose(sys_src_ext_out)
        |-> $past(mode_out) == 3'h0) else $error("source switched outside active");
    a_mode_legal: assert property (mode_out <= 3'h5)
        else $error("mode code out of range");
endmodule

bind pdw_power_ctrl pdw_power_ctrl_sva i_sva (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out), .sleep_exec_in(sleep_exec_in),
    .cpu_clk_en_out(cpu_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
    .sys_src_ext_out(sys_src_ext_out), .mode_out(mode_out)
);

// >>> tb/tb_power_down_wake_wait_control.sv
// Self-checking bench for the power-down and wake-wait controller.
// Drives the Avalon slave and the oscillator tick pins directly.
`timescale 1ns/10ps
module tb_power_down_wake_wait_control;
    logic        mclk_in  = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [3:0]  adr      = 4'h0;
    logic        rd       = 1'b0;
    logic        wr       = 1'b0;
    logic [31:0] wd       = 32'h0;
    logic [3:0]  be       = 4'hF;
    logic        slp      = 1'b0;
    logic        wake     = 1'b0;
    logic        osc      = 1'b0;
    logic        ext_t    = 1'b0;
    logic        rc_t     = 1'b0;
    logic        sub_t    = 1'b0;
    logic        rtc_en;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        wreq;
    logic        cpu_en;
    logic        src_ext;
    logic [2:0]  mode;
    int          miscompares = 0;
    int          cmp_count   = 0;
    int          cpu_pulses  = 0;
    int          rtc_pulses  = 0;

    always #4 mclk_in = ~mclk_in;

    // Running totals of enable pulses; scenarios compare differences
    always @(posedge mclk_in) begin
        if (cpu_en === 1'b1) begin
            cpu_pulses <= cpu_pulses + 1;
        end
        if (rtc_en === 1'b1) begin
            rtc_pulses <= rtc_pulses + 1;
        end
    end

    pdw_power_ctrl i_dut (
        .mclk_in             (mclk_in),
        .rst_n_in            (rst_n_in),
        .avs_address_in      (adr),
        .avs_read_in         (rd),
        .avs_write_in        (wr),
        .avs_writedata_in    (wd),
        .avs_byteenable_in   (be),
        .avs_readdata_out    (rdata),
        .avs_waitrequest_out (wreq),
        .sleep_exec_in       (slp),
        .wake_event_in       (wake),
        .osc_started_in      (osc),
        .ext_osc_tick_in     (ext_t),
        .rc_osc_tick_in      (rc_t),
        .sub_clk_tick_in     (sub_t),
        .cpu_clk_en_out      (cpu_en),
        .periph_clk_en_out   (),
        .rtc_clk_en_out      (rtc_en),
        .osc_enable_out      (),
        .sys_src_ext_out     (src_ext),
        .mode_out            (mode)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        rd  <= !w;
        wr  <= w;
        adr <= a;
        wd  <= d;
        do begin
            @(posedge mclk_in);
        end while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Two cycles high, two low, so the pin synchroniser sees every edge
    task automatic ticks(input int n, input logic e);
        repeat (n) begin
            @(posedge mclk_in);
            ext_t <= e;
            rc_t  <= !e;
            sub_t <= 1'b1;
            repeat (2) @(posedge mclk_in);
            ext_t <= 1'b0;
            rc_t  <= 1'b0;
            sub_t <= 1'b0;
            @(posedge mclk_in);
        end
    endtask

    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (mode !== m && n < 200) begin
            @(posedge mclk_in);
            n++;
        end
        chk(mode, m);
    endtask

    task automatic pulse_sleep;
        @(posedge mclk_in);
        slp <= 1'b1;
        @(posedge mclk_in);
        slp <= 1'b0;
    endtask

    task automatic wake_pulse;
        @(posedge mclk_in);
        wake <= 1'b1;
        repeat (3) @(posedge mclk_in);
        wake <= 1'b0;
    endtask

    // software wait choice
    // Wait code 111 gives 512 source ticks; tick pins carry no time scale
    task automatic settle(input logic e);
        osc <= 1'b1;
        repeat (4) @(posedge mclk_in);
        ticks(511, e);
        repeat (6) @(posedge mclk_in);
        chk(mode, 3'h5);
        ticks(1, e);
        wait_mode(3'h0);
        osc <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rdchk(4'h0, 32'h0);
        rdchk(4'h4, 32'h0);
        rdchk(4'hC, 32'h0);
        bus(1'b1, 4'h0, 32'hFFFFFFFF);
        rdchk(4'h0, 32'hF0);
        be <= 4'hE;
        bus(1'b1, 4'h0, 32'h0);
        be <= 4'hF;
        rdchk(4'h0, 32'hF0);
        bus(1'b1, 4'h1, 32'hFF);
        rdchk(4'h1, 32'h0);
        bus(1'b1, 4'h4, 32'hFF);
        rdchk(4'h4, 32'hE7);
    endtask

    task automatic t_modes;
        bus(1'b1, 4'h0, 32'h70);
        bus(1'b1, 4'h4, 32'h0);
        pulse_sleep;
        wait_mode(3'h1);
        wake_pulse;
        wait_mode(3'h0);
        bus(1'b1, 4'h4, 32'h40);
        pulse_sleep;
        wait_mode(3'h3);
        rdchk(4'hC, 32'h3);
        wake_pulse;
        wait_mode(3'h2);
        bus(1'b1, 4'h4, 32'h20);
        pulse_sleep;
        wait_mode(3'h5);
        settle(1'b0);
    endtask

    // Divider set to /64 so that a divided count would overrun the bound
    task automatic t_standby(input logic e);
        int base;
        bus(1'b1, 4'h0, 32'hF0);
        bus(1'b1, 4'h4, 32'h03);
        bus(1'b1, 4'h8, {29'h0, e, 2'h0});
        rdchk(4'h8, {29'h0, e, 2'h0});
        pulse_sleep;
        wait_mode(3'h4);
        base = rtc_pulses;
        ticks(4, e);
        repeat (2) @(posedge mclk_in);
        chk(rtc_pulses - base, e ? 32'h4 : 32'h0);
        wake_pulse;
        wait_mode(3'h5);
        ticks(100, e);
        settle(e);
    endtask

    task automatic t_switch;
        bus(1'b1, 4'h4, 32'h00);
        osc <= 1'b1;
        bus(1'b1, 4'h8, 32'h01);
        rdchk(4'hC, 32'h20);
        ticks(4088, 1'b0);
        repeat (6) @(posedge mclk_in);
        chk(src_ext, 1'b0);
        ticks(16, 1'b0);
        repeat (6) @(posedge mclk_in);
        chk(src_ext, 1'b1);
        rdchk(4'hC, 32'h10);
        osc <= 1'b0;
    endtask

    // Divider left at /64: 128 on-chip ticks give exactly two enables
    task automatic t_div;
        int base;
        base = cpu_pulses;
        ticks(128, 1'b0);
        repeat (6) @(posedge mclk_in);
        chk(cpu_pulses - base, 32'h2);
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_modes();
        t_standby(1'b0);
        t_switch();
        t_standby(1'b1);
        bus(1'b1, 4'h8, 32'h02);
        rdchk(4'hC, 32'h0);
        t_div();
        test_done();
    end

    // Whole run is near 25k cycles
    initial begin
        repeat (60000) @(posedge mclk_in);
        miscompares++;
        test_done();
    end
endmodule
